// ### hw/clk_cfg_defines.svh
/*
  Register map, field positions, reset values and timing counts for the
  sync clock, ramp overflow gating and reference clock input configuration.
  Assumes a 100 MHz register clock and word-aligned APB access.
*/
`ifndef CLK_CFG_DEFINES_SVH
`define CLK_CFG_DEFINES_SVH

// ==========================================================================
// Register indices and byte addresses
// ==========================================================================
`define CW1_IDX          8'h00
`define CW2_IDX          8'h01
`define CIC_IDX          8'h02
`define STAT_IDX         8'h04
`define CW1_ADDR         8'h00
`define CW2_ADDR         8'h04
`define CIC_ADDR         8'h08
`define STAT_ADDR        8'h10

// ==========================================================================
// Field positions
// ==========================================================================
`define CW1_VCO_CAL_BIT  24
`define CW2_OVF_EN_BIT   13
`define CW2_SYNC_EN_BIT  11
`define CW2_SYNC_INV_BIT 10
`define CIC_DIV_RST_BIT  22
`define CIC_DIV_HI       21
`define CIC_DIV_LO       20
`define CIC_DBL_EN_BIT   19
`define CIC_PLL_EN_BIT   18
`define CIC_DIV_EN_BIT   17
`define CIC_DBL_EDGE_BIT 16
`define CIC_N_HI         15
`define CIC_N_LO         8

// ==========================================================================
// Writable masks and reset values
// ==========================================================================
`define CW1_MASK         32'h0100_0000
`define CW2_MASK         32'h0000_2C00
`define CIC_MASK         32'h007F_FF00
`define CW2_RESET        32'h0000_0800
`define CIC_RESET        32'h0000_1900
`define N_MIN            8'h0A

// ==========================================================================
// Timing
// ==========================================================================
`define CLK_MHZ          100
`define CAL_TIME_NS      1000
`define CAL_CYCLES       ((`CAL_TIME_NS * `CLK_MHZ + 999) / 1000)
`define SYNC_HALF_CYCLES 4'h2

`endif

// ### hw/clk_cfg_pkg.sv
/*
  Types shared by the clock input configuration block.
  Assumes the defines header is compiled alongside.
*/
package clk_cfg_pkg;
  // ==========================================================================
  // Calibration sequencer states
  // ==========================================================================
  typedef enum logic [0:0] {
    CAL_IDLE = 1'b0,
    CAL_RUN  = 1'b1
  } cal_state_type;
endpackage : clk_cfg_pkg

// ### hw/ref_input_path.sv
/*
  Reference clock input path: pin synchroniser, optional edge doubling and
  a power-of-two divider that emits one tick per divided reference period.
  Assumes the reference is well below half the register clock rate.
*/
module ref_input_path (
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  input  wire logic       ref_clk_i,
  input  wire logic       dbl_use_i,
  input  wire logic [1:0] div_code_i,
  input  wire logic       div_rst_i,
  output logic            tick_o
);
  logic       sync1_reg;
  logic       sync2_reg;
  logic       last_reg;
  logic [2:0] cnt_reg;
  logic [2:0] limit;
  logic       ref_evt;

  // ==========================================================================
  // Pin synchroniser and edge history
  // ==========================================================================
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
      last_reg  <= 1'b0;
    end else begin
      sync1_reg <= ref_clk_i;
      sync2_reg <= sync1_reg;
      last_reg  <= sync2_reg;
    end
  end

  // Both edges count only with doubling in use
  assign ref_evt = (sync2_reg & ~last_reg) | (dbl_use_i & ~sync2_reg & last_reg);
  assign limit   = 3'((4'h1 << div_code_i) - 4'h1);

  // Divider, held cleared while its reset bit stands
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_reg <= 3'h0;
      tick_o  <= 1'b0;
    end else if (div_rst_i) begin
      cnt_reg <= 3'h0;
      tick_o  <= 1'b0;
    end else begin
      tick_o  <= ref_evt && (cnt_reg >= limit);
      if (ref_evt) begin
        cnt_reg <= (cnt_reg >= limit) ? 3'h0 : cnt_reg + 3'h1;
      end
    end
  end
endmodule : ref_input_path

// ### hw/sync_clk_gen.sv
/*
  Internal sync clock: a free running square wave marking Q (high) and
  I (low) halves of the data assembler cycle.
  Assumes one register clock domain; never gated by the pin enable.
*/
`include "clk_cfg_defines.svh"

module sync_clk_gen (
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  output logic      q_phase_o
);
  logic [3:0] cnt_reg;

  // Runs regardless of the pin enable so the assembler keeps its timing
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_reg   <= 4'h0;
      q_phase_o <= 1'b0;
    end else if (cnt_reg == `SYNC_HALF_CYCLES - 4'h1) begin
      cnt_reg   <= 4'h0;
      q_phase_o <= ~q_phase_o;
    end else begin
      cnt_reg   <= cnt_reg + 4'h1;
    end
  end
endmodule : sync_clk_gen

// ### hw/clock_input_ctrl.sv
/*
  Clock routing configuration: APB register file holding the second and
  third control words, VCO calibration start, ramp overflow pin gating,
  sync clock pin, reference input path and PLL enable.
  Assumes an APB master on clk_i and the reference clock on a pin.
*/
`include "clk_cfg_defines.svh"

module clock_input_ctrl
  import clk_cfg_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [31:0] pwdata_i,
  output logic [31:0]      prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  input  wire logic        ref_clk_i,
  input  wire logic        ramp_over_i,
  output logic             ramp_overflow_pin_o,
  output logic             ramp_overflow_oe_n_o,
  output logic             sync_clk_pin_o,
  output logic             sync_q_phase_o,
  output logic             pll_ref_tick_o,
  output logic             pll_enable_o,
  output logic [8:0]       pll_mult_o,
  output logic             vco_cal_busy_o
);

  // ==========================================================================
  // Storage
  // ==========================================================================
  logic [31:0]   cw2_reg;
  logic [31:0]   cw2_next;
  logic [31:0]   cic_reg;
  logic [31:0]   cic_next;
  logic          calibrated_reg;
  logic          calibrated_next;
  cal_state_type cal_state_reg;
  cal_state_type cal_state_next;
  logic [7:0]    cal_cnt_reg;
  logic [7:0]    cal_cnt_next;
  logic [8:0]    mult_reg;

  // ==========================================================================
  // APB decode
  // ==========================================================================
  wire        setup_phase = psel_i & ~penable_i;
  wire        wr_access   = psel_i & penable_i & pready_o & pwrite_i;
  wire        hit_cw1     = (paddr_i == `CW1_ADDR);
  wire        hit_cw2     = (paddr_i == `CW2_ADDR);
  wire        hit_cic     = (paddr_i == `CIC_ADDR);
  wire        hit_stat    = (paddr_i == `STAT_ADDR);
  wire        hit_any     = hit_cw1 | hit_cw2 | hit_cic | hit_stat;
  wire        wr_cw1      = wr_access & hit_cw1;
  wire        wr_cw2      = wr_access & hit_cw2;
  wire        wr_cic      = wr_access & hit_cic;
  wire [7:0]  wr_n        = pwdata_i[`CIC_N_HI:`CIC_N_LO];
  wire        n_ok        = (wr_n >= `N_MIN);
  wire        cal_start   = wr_cw1 & pwdata_i[`CW1_VCO_CAL_BIT];
  wire [31:0] cw1_view    = {7'h00, (cal_state_reg == CAL_RUN), 24'h00_0000};
  wire [31:0] stat_view   = {29'h0000_0000, pll_enable_o, calibrated_reg, vco_cal_busy_o};

  // Read mux; open bits were never stored so they read zero
  wire [31:0] rd_mux = hit_cw1  ? cw1_view :
                       hit_cw2  ? cw2_reg  :
                       hit_cic  ? cic_reg  :
                       hit_stat ? stat_view : 32'h0000_0000;

  // Writes keep only documented fields; N below range keeps the old value
  assign cw2_next = wr_cw2 ? (pwdata_i & `CW2_MASK) : cw2_reg;
  assign cic_next = !wr_cic ? cic_reg :
                    {cic_reg[31:23] & 9'h000, pwdata_i[22:16],
                     n_ok ? wr_n : cic_reg[`CIC_N_HI:`CIC_N_LO], 8'h00};

  // ==========================================================================
  // APB answer: one wait-free access phase, registered outputs
  // ==========================================================================
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o  <= 32'h0000_0000;
    end else begin
      pready_o  <= setup_phase;
      pslverr_o <= setup_phase & ~hit_any;
      prdata_o  <= (setup_phase & ~pwrite_i) ? rd_mux : 32'h0000_0000;
    end
  end

  // Control words
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cw2_reg <= `CW2_RESET;
      cic_reg <= `CIC_RESET;
    end else begin
      cw2_reg <= cw2_next;
      cic_reg <= cic_next;
    end
  end

  // ==========================================================================
  // Field views
  // ==========================================================================
  wire       ovf_en    = cw2_reg[`CW2_OVF_EN_BIT];
  wire       sync_en   = cw2_reg[`CW2_SYNC_EN_BIT];
  wire       sync_inv  = cw2_reg[`CW2_SYNC_INV_BIT];
  wire       div_rst   = cic_reg[`CIC_DIV_RST_BIT];
  wire [1:0] div_code  = cic_reg[`CIC_DIV_HI:`CIC_DIV_LO];
  wire       div_en    = cic_reg[`CIC_DIV_EN_BIT];
  wire       pll_en    = cic_reg[`CIC_PLL_EN_BIT];
  // Divider setting reaches the PLL only with its enable set
  wire [1:0] eff_code  = div_en ? div_code : 2'b00;
  // Doubling needs both the feature and the circuit enabled
  wire       dbl_use   = cic_reg[`CIC_DBL_EN_BIT] & cic_reg[`CIC_DBL_EDGE_BIT];

  // ==========================================================================
  // Pins: overflow gating and sync clock
  // ==========================================================================
  // Overflow pin is released rather than driven low when disabled
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ramp_overflow_pin_o  <= 1'b0;
      ramp_overflow_oe_n_o <= 1'b1;
      sync_clk_pin_o       <= 1'b0;
    end else begin
      ramp_overflow_pin_o  <= ovf_en & ramp_over_i;
      ramp_overflow_oe_n_o <= ~ovf_en;
      // Static low when disabled; Q half high unless inverted
      sync_clk_pin_o       <= sync_en & (sync_q_phase_o ^ sync_inv);
    end
  end

  sync_clk_gen u_sync (
    .clk_i     (clk_i),
    .rst_n_i   (rst_n_i),
    .q_phase_o (sync_q_phase_o)
  );

  ref_input_path u_ref (
    .clk_i      (clk_i),
    .rst_n_i    (rst_n_i),
    .ref_clk_i  (ref_clk_i),
    .dbl_use_i  (dbl_use),
    .div_code_i (eff_code),
    .div_rst_i  (div_rst),
    .tick_o     (pll_ref_tick_o)
  );

  // ==========================================================================
  // PLL enable, multiplier and VCO calibration
  // ==========================================================================
  // Calibration only counts while the PLL runs; disabling aborts it
  always_comb begin
    cal_state_next  = cal_state_reg;
    cal_cnt_next    = cal_cnt_reg;
    calibrated_next = calibrated_reg & pll_en;
    case (cal_state_reg)
      CAL_IDLE: begin
        if (cal_start && pll_en) begin
          cal_state_next  = CAL_RUN;
          cal_cnt_next    = 8'(`CAL_CYCLES - 1);
          calibrated_next = 1'b0;
        end
      end
      CAL_RUN: begin
        if (!pll_en) begin
          cal_state_next = CAL_IDLE;
        end else if (cal_cnt_reg == 8'h00) begin
          cal_state_next  = CAL_IDLE;
          calibrated_next = 1'b1;
        end else begin
          cal_cnt_next = cal_cnt_reg - 8'h01;
        end
      end
      default: begin
        cal_state_next = CAL_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cal_state_reg  <= CAL_IDLE;
      cal_cnt_reg    <= 8'h00;
      calibrated_reg <= 1'b0;
      vco_cal_busy_o <= 1'b0;
      pll_enable_o   <= 1'b0;
      mult_reg       <= 9'h032;
    end else begin
      cal_state_reg  <= cal_state_next;
      cal_cnt_reg    <= cal_cnt_next;
      calibrated_reg <= calibrated_next;
      vco_cal_busy_o <= (cal_state_next == CAL_RUN);
      pll_enable_o   <= pll_en;
      mult_reg       <= {cic_reg[`CIC_N_HI:`CIC_N_LO], 1'b0};
    end
  end

  assign pll_mult_o = mult_reg;

  // ==========================================================================
  // Checks
  // ==========================================================================
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  chk_ovf_gated: assert property (!ovf_en |=> ramp_overflow_oe_n_o && !ramp_overflow_pin_o)
    else $error("overflow pin driven while disabled");
  chk_ovf_follows: assert property (ovf_en |=> ramp_overflow_pin_o == $past(ramp_over_i))
    else $error("overflow pin not following ramp overflow");
  chk_sync_static: assert property (!sync_en |=> !sync_clk_pin_o)
    else $error("sync pin not held low");
  chk_sync_polarity: assert property (sync_en |=> sync_clk_pin_o == ($past(sync_q_phase_o) ^ $past(sync_inv)))
    else $error("sync pin polarity wrong");
  chk_sync_running: assert property ($rose(sync_q_phase_o) |-> sync_q_phase_o[*2] ##1 !sync_q_phase_o)
    else $error("internal sync clock stalled");
  chk_div_reset: assert property (div_rst |=> !pll_ref_tick_o)
    else $error("reference tick during divider reset");
  chk_div_bypass: assert property (!div_en |-> eff_code == 2'b00)
    else $error("divider applied while disabled");
  chk_dbl_needs_both: assert property (dbl_use |-> cic_reg[`CIC_DBL_EN_BIT] && cic_reg[`CIC_DBL_EDGE_BIT])
    else $error("doubler used without both enables");
  chk_n_range: assert property (pll_mult_o >= 9'h014)
    else $error("multiplier below minimum");
  chk_pll_drop: assert property ($fell(pll_en) |=> !calibrated_reg && !vco_cal_busy_o)
    else $error("calibration survived PLL disable");
  chk_open_zero: assert property (pready_o && !pwrite_i |-> (prdata_o & ~(`CW2_MASK | `CIC_MASK | `CW1_MASK | 32'h0000_0007)) == 32'h0000_0000)
    else $error("open bits read nonzero");

  // ==========================================================================
  // Register bus checks
  // ==========================================================================
  // Every setup cycle is answered on the very next edge, never held longer
  chk_ready_setup: assert property (setup_phase |=> pready_o)
    else $error("no answer after setup");
  // A held answer would let one access be taken twice
  chk_ready_pulse: assert property (pready_o |=> !pready_o)
    else $error("answer stood more than one cycle");
  // Unmapped addresses answer with an error
  chk_err_unmapped: assert property (setup_phase && !hit_any |=> pslverr_o)
    else $error("unmapped access without error");
  // Read data is zero outside the access phase of a read
  chk_rdata_idle: assert property (!pready_o |-> prdata_o == 32'h0000_0000)
    else $error("read data outside access phase");

  // ==========================================================================
  // Register content checks
  // ==========================================================================
  // Open and reserved bits never get stored
  chk_cw2_open: assert property ((cw2_reg & ~`CW2_MASK) == 32'h0000_0000)
    else $error("open bit stored in word two");
  chk_cic_open: assert property ((cic_reg & ~`CIC_MASK) == 32'h0000_0000)
    else $error("open bit stored in clock input config");
  // N below range leaves the old value in place
  chk_n_kept: assert property (wr_cic && !n_ok |=> $stable(cic_reg[`CIC_N_HI:`CIC_N_LO]))
    else $error("illegal N was stored");
  // A legal N is taken as written
  chk_n_taken: assert property (wr_cic && n_ok |=> cic_reg[`CIC_N_HI:`CIC_N_LO] == $past(wr_n))
    else $error("legal N not stored");
  // Multiplier is always twice the stored N, one cycle later
  chk_mult_double: assert property (1'b1 |=> pll_mult_o == {$past(cic_reg[`CIC_N_HI:`CIC_N_LO]), 1'b0})
    else $error("multiplier not twice N");

  // ==========================================================================
  // PLL, divider and pin checks
  // ==========================================================================
  // Enable output is the register bit one cycle late
  chk_pll_copy: assert property (1'b1 |=> pll_enable_o == $past(pll_en))
    else $error("PLL enable output wrong");
  // A start with the PLL running makes the sequencer busy at once
  chk_cal_start: assert property (cal_start && pll_en && cal_state_reg == CAL_IDLE |=> vco_cal_busy_o)
    else $error("calibration did not start");
  // No calibration runs while the PLL is off
  chk_cal_off: assert property (!pll_en |=> !vco_cal_busy_o)
    else $error("calibration busy with PLL off");
  // Enabled overflow pin is actively driven
  chk_ovf_driven: assert property (ovf_en |=> !ramp_overflow_oe_n_o)
    else $error("overflow pin not driven while enabled");
  // With its enable set the divider code passes unchanged
  chk_div_pass: assert property (div_en |-> eff_code == div_code)
    else $error("divider code lost while enabled");
  // Edge bit alone never doubles
  chk_dbl_edge_only: assert property (!cic_reg[`CIC_DBL_EN_BIT] |-> !dbl_use)
    else $error("doubling without doubler enable");

  cov_cal_done: cover property ($fell(vco_cal_busy_o) && calibrated_reg);
  cov_dbl_tick: cover property (dbl_use && pll_ref_tick_o);
  cov_div8_tick: cover property (eff_code == 2'b11 && pll_ref_tick_o);
  cov_bad_addr: cover property (pslverr_o);

endmodule : clock_input_ctrl

// ### tb/sync_clock_and_pll_input_config_tb.sv
/*
  Self-checking bench for the clock input configuration block: APB register
  access, overflow gating, sync clock pin, reference divider and calibration.
  Assumes the design files and the defines header are compiled first.
*/
`include "clk_cfg_defines.svh"

module sync_clock_and_pll_input_config_tb;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct packed { logic [31:0] data; logic err; } note_type;
  // ==========================================================================
  // Signals
  // ==========================================================================
  logic        clk_i = 1'b0;
  logic        rst_n_i = 1'b0;
  logic [7:0]  paddr_i;
  logic        psel_i = 1'b0;
  logic        penable_i = 1'b0;
  logic        pwrite_i = 1'b0;
  logic [31:0] pwdata_i;
  logic [31:0] prdata_o;
  logic        pready_o, pslverr_o;
  logic        ref_clk_i = 1'b0;
  logic        ramp_over_i = 1'b0;
  logic        ramp_overflow_pin_o, ramp_overflow_oe_n_o, sync_clk_pin_o, sync_q_phase_o;
  logic        pll_ref_tick_o, pll_enable_o, vco_cal_busy_o;
  logic [8:0]  pll_mult_o;
  int          miscompares = 0;
  int          cmp_count = 0;
  int          tick_cnt = 0;
  int          busy_cnt = 0;
  int          ref_div = 0;
  int          t0, d, i, j, k, b0, toggles;
  logic [31:0] rnd, w;
  logic        qp, prev;
  note_type    exp_q[$];
  note_type    note;
  logic [31:0] cfg_tab [9] = '{32'h0030_1900, 32'h0002_1900, 32'h0012_1900, 32'h0022_1900, 32'h0032_1900,
                                32'h0008_1900, 32'h0009_1900, 32'h0001_1900, 32'h0042_1900};
  int          exp_tab [9] = '{64, 64, 32, 16, 8, 64, 128, 64, 0};

  clock_input_ctrl dut_u (
    .clk_i                (clk_i),
    .rst_n_i              (rst_n_i),
    .paddr_i              (paddr_i),
    .psel_i               (psel_i),
    .penable_i            (penable_i),
    .pwrite_i             (pwrite_i),
    .pwdata_i             (pwdata_i),
    .prdata_o             (prdata_o),
    .pready_o             (pready_o),
    .pslverr_o            (pslverr_o),
    .ref_clk_i            (ref_clk_i),
    .ramp_over_i          (ramp_over_i),
    .ramp_overflow_pin_o  (ramp_overflow_pin_o),
    .ramp_overflow_oe_n_o (ramp_overflow_oe_n_o),
    .sync_clk_pin_o       (sync_clk_pin_o),
    .sync_q_phase_o       (sync_q_phase_o),
    .pll_ref_tick_o       (pll_ref_tick_o),
    .pll_enable_o         (pll_enable_o),
    .pll_mult_o           (pll_mult_o),
    .vco_cal_busy_o       (vco_cal_busy_o)
  );

  // ==========================================================================
  // Clock, reference pin and helpers
  // ==========================================================================
  always #5 clk_i = ~clk_i;

  // Reference period of 8 clocks keeps it well under a quarter of clk
  always @(posedge clk_i) begin
    ref_div <= ref_div + 1;
    if (ref_div % 4 == 3) ref_clk_i <= ~ref_clk_i;
  end

  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    s = s ^ (s << 5);
    return s;
  endfunction : xs

  task automatic chk(input logic ok, input string msg);
    cmp_count++;
    if (ok !== 1'b1) begin
      miscompares++;
      $display("[ERR] %0t %s", $time, msg);
    end
  endtask : chk

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : end_sim

  // One APB transfer; reads leave their expected answer in the queue
  task automatic apb(input logic [7:0] a, input logic wr, input logic [31:0] wd, input logic [31:0] e,
                     input logic er);
    int n;
    if (!wr) exp_q.push_back('{data: e, err: er});
    @(posedge clk_i);
    psel_i    <= 1'b1;
    penable_i <= 1'b0;
    paddr_i   <= a;
    pwrite_i  <= wr;
    pwdata_i  <= wd;
    @(posedge clk_i);
    penable_i <= 1'b1;
    for (n = 0; n < 20; n++) begin
      @(posedge clk_i);
      if (pready_o === 1'b1) break;
    end
    if (n == 20) begin
      chk(1'b0, "no pready");
      end_sim();
    end
    psel_i    <= 1'b0;
    penable_i <= 1'b0;
  endtask : apb

  // ==========================================================================
  // Watcher: counts pulses and checks each read against the oldest note
  // ==========================================================================
  always @(posedge clk_i) begin
    if (pll_ref_tick_o === 1'b1) tick_cnt <= tick_cnt + 1;
    if (vco_cal_busy_o === 1'b1) busy_cnt <= busy_cnt + 1;
    if (psel_i && penable_i && !pwrite_i && pready_o === 1'b1) begin
      if (exp_q.size() == 0) chk(1'b0, "read without note");
      else begin
        note = exp_q.pop_front();
        chk(prdata_o === note.data && pslverr_o === note.err, "read data or error");
      end
    end
  end

  // ==========================================================================
  // Main sequence
  // ==========================================================================
  initial begin
    paddr_i  = 8'h00;
    pwdata_i = 32'h0000_0000;
    rnd      = 32'h0000_60de;
    repeat (12) @(posedge clk_i);
    rst_n_i <= 1'b1;
    chk(pll_mult_o === 9'h032 && pll_enable_o === 1'b0 && ramp_overflow_oe_n_o === 1'b1, "reset pins");
    apb(`CW2_ADDR, 1'b0, 32'h0, `CW2_RESET, 1'b0);
    apb(`CIC_ADDR, 1'b0, 32'h0, `CIC_RESET, 1'b0);
    $display("test reset done");
    // Random data into open bits, PLL kept off and N kept legal
    rnd = xs(rnd);
    apb(`CW2_ADDR, 1'b1, rnd, 32'h0, 1'b0);
    apb(`CW2_ADDR, 1'b0, 32'h0, rnd & `CW2_MASK, 1'b0);
    rnd = xs(rnd);
    w = (rnd & 32'hFFFB_00FF) | 32'h0000_3200;
    apb(`CIC_ADDR, 1'b1, w, 32'h0, 1'b0);
    apb(`CIC_ADDR, 1'b0, 32'h0, w & `CIC_MASK, 1'b0);
    apb(8'h0C, 1'b0, 32'h0, 32'h0, 1'b1);
    repeat (2) @(posedge clk_i);
    chk(pll_mult_o === 9'h064, "mult 100");
    apb(`CIC_ADDR, 1'b1, 32'h0000_0900, 32'h0, 1'b0);
    repeat (2) @(posedge clk_i);
    chk(pll_mult_o === 9'h064, "N 9 refused");
    apb(`CIC_ADDR, 1'b1, 32'h0000_0A00, 32'h0, 1'b0);
    repeat (2) @(posedge clk_i);
    chk(pll_mult_o === 9'h014, "N 10");
    apb(`CIC_ADDR, 1'b1, 32'h0000_FF00, 32'h0, 1'b0);
    repeat (2) @(posedge clk_i);
    chk(pll_mult_o === 9'h1FE, "N 255");
    $display("test registers done");
    // Reference path: ticks over 64 reference periods, one tick of slack
    for (i = 0; i < 9; i++) begin
      apb(`CIC_ADDR, 1'b1, cfg_tab[i], 32'h0, 1'b0);
      repeat (16) @(posedge clk_i);
      t0 = tick_cnt;
      repeat (512) @(posedge clk_i);
      d = tick_cnt - t0 - exp_tab[i];
      chk(d >= -1 && d <= 1, "reference tick count");
    end
    $display("test reference done");
    // Overflow pin follows last cycle's ramp flag only when enabled
    for (j = 0; j < 2; j++) begin
      apb(`CW2_ADDR, 1'b1, j ? 32'h0000_2000 : 32'h0000_0000, 32'h0, 1'b0);
      repeat (3) @(posedge clk_i);
      #1;
      chk(ramp_overflow_oe_n_o === !j[0], "overflow enable");
      repeat (8) begin
        prev = ramp_over_i;
        @(posedge clk_i);
        rnd = xs(rnd);
        ramp_over_i <= rnd[0];
        #1;
        chk(ramp_overflow_pin_o === (j[0] & prev), "overflow pin");
      end
    end
    $display("test overflow done");
    // Sync pin for each enable and invert pair; internal clock never stops
    for (j = 0; j < 4; j++) begin
      apb(`CW2_ADDR, 1'b1, j << 10, 32'h0, 1'b0);
      repeat (3) @(posedge clk_i);
      #1;
      toggles = 0;
      repeat (8) begin
        qp = sync_q_phase_o;
        @(posedge clk_i);
        #1;
        chk(sync_clk_pin_o === (j[1] & (qp ^ j[0])), "sync pin");
        if (sync_q_phase_o !== qp) toggles++;
      end
      chk(toggles == 4, "internal sync clock");
    end
    $display("test sync done");
    // PLL on, calibration started by software, then PLL off
    apb(`CIC_ADDR, 1'b1, 32'h0004_1900, 32'h0, 1'b0);
    repeat (2) @(posedge clk_i);
    chk(pll_enable_o === 1'b1, "pll on");
    apb(`STAT_ADDR, 1'b0, 32'h0, 32'h0000_0004, 1'b0);
    b0 = busy_cnt;
    apb(`CW1_ADDR, 1'b1, 32'h0100_0000, 32'h0, 1'b0);
    apb(`CW1_ADDR, 1'b0, 32'h0, 32'h0100_0000, 1'b0);
    for (k = 0; k < 300; k++) begin
      @(posedge clk_i);
      if (vco_cal_busy_o === 1'b0) break;
    end
    @(posedge clk_i);
    d = busy_cnt - b0;
    chk(k < 300 && d >= 99 && d <= 101, "calibration length");
    apb(`STAT_ADDR, 1'b0, 32'h0, 32'h0000_0006, 1'b0);
    apb(`CIC_ADDR, 1'b1, 32'h0000_1900, 32'h0, 1'b0);
    repeat (2) @(posedge clk_i);
    chk(pll_enable_o === 1'b0, "pll off");
    apb(`STAT_ADDR, 1'b0, 32'h0, 32'h0000_0000, 1'b0);
    $display("test pll done");
    end_sim();
  end
endmodule : sync_clock_and_pll_input_config_tb
